/* inc/bdcs_pkg.sv */
// Constants, command codes and state type of the board control and status register set.
// Assumes a single 20 MHz clock domain; shared by the register set and its watchdog.
package bdcs_pkg;

	// ----------------------------------------------------------------
	// Bus addressing and command codes
	// ----------------------------------------------------------------
	// Device identifier in its 8-bit write form; bits 7:1 are the 7-bit address.
	localparam logic [7:0] DEV_ADDR = 8'h5C;
	localparam logic [7:0] CMD_CONTROL_WRITE = 8'hA0; // Write-only control.
	localparam logic [7:0] CMD_CONTROL_READBACK = 8'hA1; // Read-only control.
	localparam logic [7:0] CMD_STATUS_FIRST_CLEAR = 8'hB0; // Write clears status 0.
	localparam logic [7:0] CMD_STATUS_FIRST_READ = 8'hB1; // Read status 0.
	localparam logic [7:0] CMD_STATUS_SECOND_CLEAR = 8'hB2; // Write clears status 1.
	localparam logic [7:0] CMD_STATUS_SECOND_READ = 8'hB3; // Read status 1.
	localparam logic [7:0] CMD_LOGIC_REVISION = 8'hC1; // Read revision.
	// Value returned for any read command that is not mapped.
	localparam logic [7:0] UNMAPPED_DATA = 8'hFF;

	// ----------------------------------------------------------------
	// Register fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int CTRL_FULL_RESET_BIT = 0;
	localparam int CTRL_PG_LED_BIT = 1;
	localparam int CTRL_RETRIGGER_BIT = 2;
	localparam int CTRL_WDG_SEL_LSB = 3; // Two-bit field at 4:3.
	localparam int CTRL_HANDLE_MODE_BIT = 5;
	localparam int CTRL_HANDLE_DISABLE_BIT = 6;
	localparam int CTRL_GP_LED_BIT = 7;
	localparam int ST1_ARMED_BIT = 7;
	localparam int ST1_WDG_RESET_BIT = 6;
	localparam int ST1_HALF_BIT = 5;
	localparam int ST1_POWER_FAIL_W = 5; // Sticky power-fail flags at 4:0.

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_TIME_US = 1000; // Watchdog time base, 1 ms.
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;
	localparam int TICKS_PER_S = 1_000_000 / TICK_TIME_US;
	localparam int WDG_TIME0_S = 2;
	localparam int WDG_TIME1_S = 10;
	localparam int WDG_TIME2_S = 50;
	localparam int WDG_TIME3_S = 250;
	localparam int WDG_CNT_W = 18; // Holds 250 s in 1 ms ticks.
	localparam int TICK_CNT_W = 24;

	// ----------------------------------------------------------------
	// Serial slave states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} bdcs_state_type;

endpackage

/* hdl/bdcs_watchdog.sv */
// Watchdog of the register set: armed by any change of the retrigger bit.
// Assumes a one-cycle tick enable every watchdog time base from the parent.
`timescale 1ns/1ps
`default_nettype none

module bdcs_watchdog (
	// Clock and resets.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sys_rst_i,
	// Control from the register set.
	input wire logic tick_i,
	input wire logic retrigger_i,
	input wire logic [1:0] sel_i,
	// Status back to the register set.
	output logic armed_o,
	output logic half_o,
	output logic expire_o
);

	// ----------------------------------------------------------------
	// Timeout limit in ticks
	// ----------------------------------------------------------------
	// Field bits are read as {first, second}: 00 2 s, 10 10 s, 01 50 s, 11 250 s.
	function automatic logic [bdcs_pkg::WDG_CNT_W-1:0] wdg_limit(input logic [1:0] sel);
		int secs;
		unique case (sel)
			2'h0: secs = bdcs_pkg::WDG_TIME0_S;
			2'h2: secs = bdcs_pkg::WDG_TIME1_S;
			2'h1: secs = bdcs_pkg::WDG_TIME2_S;
			2'h3: secs = bdcs_pkg::WDG_TIME3_S;
		endcase
		return bdcs_pkg::WDG_CNT_W'(secs * bdcs_pkg::TICKS_PER_S);
	endfunction

	logic armed; // Watchdog running.
	logic retrig_q; // Last seen retrigger bit, for change detection.
	logic [bdcs_pkg::WDG_CNT_W-1:0] count; // Elapsed ticks since last retrigger.
	logic expire; // One-cycle timeout pulse.
	logic next_armed;
	logic next_retrig_q;
	logic [bdcs_pkg::WDG_CNT_W-1:0] next_count;
	logic next_expire;
	logic [bdcs_pkg::WDG_CNT_W-1:0] limit;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// A system reset disarms; any change of the bit arms and restarts the count.
	always_comb begin
		limit = wdg_limit(sel_i);
		next_retrig_q = retrigger_i;
		next_armed = armed;
		next_count = count;
		next_expire = 1'b0;
		if (sys_rst_i) begin
			next_armed = 1'b0;
			next_count = '0;
		end else if (retrigger_i != retrig_q) begin
			next_armed = 1'b1;
			next_count = '0;
		end else if (armed && tick_i) begin
			// Comparing against the live limit means a shorter selection takes effect at once.
			if (count + 1'b1 >= limit) begin
				next_expire = 1'b1;
				next_armed = 1'b0;
				next_count = '0;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	// Registers only.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed <= 1'b0;
			retrig_q <= 1'b0;
			count <= '0;
			expire <= 1'b0;
		end else begin
			armed <= next_armed;
			retrig_q <= next_retrig_q;
			count <= next_count;
			expire <= next_expire;
		end
	end

	assign armed_o = armed;
	assign half_o = armed && (count >= (limit >> 1));
	assign expire_o = expire;

endmodule

`default_nettype wire

/* hdl/bdcs_regs.sv */
// Board control and status register set, an SMBus byte-data slave.
// Assumes SMBus pins from outside the clock domain and an external open-drain wire.
// Operation
// - Answer only at device identifier 0x5C.
// - Command A0 write loads control register.
// - Command A1 read returns control register.
// - Command B0 write clears first status.
// - Command B1 read returns first status.
// - Command B2 write clears second status.
// - Command B3 read returns second status.
// - Command C1 read returns fixed revision.
// - Accesses use SMBus byte-data command format.
// - Timeout field selects 2, 10, 50, 250 s.
// - Watchdog idle after reset, arms on edge.
// - Reset-cause flags sticky, cleared by write.
// - Control bit 0 forces full reset.
`timescale 1ns/1ps
`default_nettype none

module bdcs_regs #(
	parameter int TICK_CYCLES = bdcs_pkg::TICK_CYCLES,
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary revision value.
) (
	// Clock and power-on reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Board system reset, active low, from a pin.
	input wire logic sys_rst_n_i,
	// SMBus pins, open drain.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Power-fail causes from the supply monitors.
	input wire logic [7:0] power_fail_first_i,
	input wire logic [4:0] power_fail_second_i,
	// Board controls.
	output logic full_reset_o,
	output logic gp_led_o,
	output logic pg_led_blink_o,
	output logic handle_disable_o,
	output logic handle_reset_mode_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 16; // scl, sda, sys reset, 13 power-fail lines.
	logic [SW-1:0] sync1; // First stage, read only by sync2.
	logic [SW-1:0] sync2;
	logic [SW-1:0] sync3;
	logic [SW-1:0] filt; // Accepted levels.
	logic [SW-1:0] next_filt;
	logic scl_q; // Previous accepted scl, for edges.
	logic sda_q;

	// A bit is accepted only when stages two and three agree, which rejects one-cycle glitches.
	always_comb begin
		for (int i = 0; i < SW; i++) begin
			next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
		end
	end

	// Pins idle high except the fail lines; reset values match the idle bus.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= 16'h0007;
			sync2 <= 16'h0007;
			sync3 <= 16'h0007;
			filt <= 16'h0007;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			sync1 <= {power_fail_second_i, power_fail_first_i, sys_rst_n_i, sda_i, scl_i};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			scl_q <= filt[0];
			sda_q <= filt[1];
		end
	end

	logic scl;
	logic sda;
	logic sys_rst;
	logic [7:0] pf_first;
	logic [4:0] pf_second;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl = filt[0];
	assign sda = filt[1];
	assign sys_rst = ~filt[2];
	assign pf_first = filt[10:3];
	assign pf_second = filt[15:11];
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start_cond = scl & scl_q & sda_q & ~sda;
	assign stop_cond = scl & scl_q & ~sda_q & sda;

	// ----------------------------------------------------------------
	// Watchdog time base and watchdog
	// ----------------------------------------------------------------
	logic [bdcs_pkg::TICK_CNT_W-1:0] tick_cnt;
	logic tick;
	logic wdg_armed;
	logic wdg_half;
	logic wdg_expire;
	logic [7:0] control; // Control register.

	// Free-running divider giving a one-cycle enable every time base.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end
	assign tick = (tick_cnt == bdcs_pkg::TICK_CNT_W'(TICK_CYCLES - 1));

	bdcs_watchdog u_watchdog (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.sys_rst_i(sys_rst),
		.tick_i(tick),
		.retrigger_i(control[bdcs_pkg::CTRL_RETRIGGER_BIT]),
		.sel_i(control[bdcs_pkg::CTRL_WDG_SEL_LSB +: 2]),
		.armed_o(wdg_armed),
		.half_o(wdg_half),
		.expire_o(wdg_expire)
	);

	// ----------------------------------------------------------------
	// Serial slave and registers
	// ----------------------------------------------------------------
	bdcs_pkg::bdcs_state_type state;
	bdcs_pkg::bdcs_state_type next_state;
	logic [7:0] shift; // Receive and transmit shift register.
	logic [7:0] next_shift;
	logic [3:0] bit_cnt; // Bits done in the current byte.
	logic [3:0] next_bit_cnt;
	logic [1:0] byte_idx; // 0 address, 1 command, 2 data.
	logic [1:0] next_byte_idx;
	logic reading; // Address byte carried the read bit.
	logic next_reading;
	logic [7:0] command; // Latched command code.
	logic [7:0] next_command;
	logic sda_low; // Slave pulls sda low.
	logic next_sda_low;
	logic [7:0] next_control;
	logic [7:0] status_first; // Sticky power-fail causes.
	logic [7:0] next_status_first;
	logic [7:0] status_second_sticky; // Only the sticky bits 6 and 4:0 are held.
	logic [7:0] next_status_second_sticky;
	logic wdg_fired; // Watchdog reset held until the system reset arrives.
	logic next_wdg_fired;
	logic [7:0] status_second;
	logic [7:0] read_data;

	// Live watchdog bits join the sticky bits on read.
	always_comb begin
		status_second = status_second_sticky;
		status_second[bdcs_pkg::ST1_ARMED_BIT] = wdg_armed;
		status_second[bdcs_pkg::ST1_HALF_BIT] = wdg_half;
	end

	// Read multiplexer; reads never alter any flag.
	always_comb begin
		unique case (command)
			bdcs_pkg::CMD_CONTROL_READBACK: read_data = control;
			bdcs_pkg::CMD_STATUS_FIRST_READ: read_data = status_first;
			bdcs_pkg::CMD_STATUS_SECOND_READ: read_data = status_second;
			bdcs_pkg::CMD_LOGIC_REVISION: read_data = REVISION;
			default: read_data = bdcs_pkg::UNMAPPED_DATA;
		endcase
	end

	// Byte-data protocol: address, command, then either a data byte or a
	// repeated start, address with read bit and one byte sent back.
	always_comb begin
		next_state = state;
		next_shift = shift;
		next_bit_cnt = bit_cnt;
		next_byte_idx = byte_idx;
		next_reading = reading;
		next_command = command;
		next_sda_low = sda_low;
		next_control = control;
		next_wdg_fired = wdg_fired | wdg_expire;
		// New power-fail causes are ORed in after a clear, so a set wins over a clear.
		next_status_first = status_first | pf_first;
		next_status_second_sticky = status_second_sticky
			| {1'b0, wdg_expire, 1'b0, pf_second};
		if (stop_cond) begin
			next_state = bdcs_pkg::ST_IDLE;
			next_sda_low = 1'b0;
		end else if (start_cond) begin
			next_state = bdcs_pkg::ST_RX;
			next_bit_cnt = '0;
			next_byte_idx = '0;
			next_sda_low = 1'b0;
		end else begin
			unique case (state)
				bdcs_pkg::ST_IDLE: begin
					next_sda_low = 1'b0;
				end
				bdcs_pkg::ST_RX: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda};
						next_bit_cnt = bit_cnt + 1'b1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						next_bit_cnt = '0;
						if (byte_idx == 2'h0) begin
							// Other devices share the bus; stay silent for them.
							if (shift[7:1] == bdcs_pkg::DEV_ADDR[7:1]) begin
								next_reading = shift[0];
								next_sda_low = 1'b1;
								next_state = bdcs_pkg::ST_ACK;
							end else begin
								next_state = bdcs_pkg::ST_IDLE;
							end
						end else if (byte_idx == 2'h1) begin
							next_command = shift;
							next_sda_low = 1'b1;
							next_state = bdcs_pkg::ST_ACK;
						end else if (byte_idx == 2'h2) begin
							next_sda_low = 1'b1;
							next_state = bdcs_pkg::ST_ACK;
							unique case (command)
								bdcs_pkg::CMD_CONTROL_WRITE: begin
									next_control = shift;
								end
								bdcs_pkg::CMD_STATUS_FIRST_CLEAR: begin
									next_status_first = pf_first;
								end
								bdcs_pkg::CMD_STATUS_SECOND_CLEAR: begin
									next_status_second_sticky = {1'b0, wdg_expire, 1'b0, pf_second};
								end
								default: begin
									next_control = control;
								end
							endcase
						end else begin
							// Bytes beyond the byte-data format are not acknowledged.
							next_state = bdcs_pkg::ST_IDLE;
						end
					end
				end
				bdcs_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (byte_idx == 2'h0 && reading) begin
							next_shift = read_data;
							next_sda_low = ~read_data[7];
							next_bit_cnt = '0;
							next_state = bdcs_pkg::ST_TX;
						end else begin
							next_sda_low = 1'b0;
							next_byte_idx = (byte_idx == 2'h3) ? byte_idx : byte_idx + 1'b1;
							next_state = bdcs_pkg::ST_RX;
						end
					end
				end
				bdcs_pkg::ST_TX: begin
					if (scl_fall) begin
						next_bit_cnt = bit_cnt + 1'b1;
						next_shift = {shift[6:0], 1'b1};
						next_sda_low = (bit_cnt == 4'h7) ? 1'b0 : ~shift[6];
						if (bit_cnt == 4'h7) begin
							next_state = bdcs_pkg::ST_MACK;
						end
					end
				end
				bdcs_pkg::ST_MACK: begin
					// A master acknowledge repeats the byte; a no-acknowledge ends the read.
					if (scl_rise) begin
						next_state = sda ? bdcs_pkg::ST_IDLE : bdcs_pkg::ST_MACK;
					end else if (scl_fall) begin
						next_shift = read_data;
						next_sda_low = ~read_data[7];
						next_bit_cnt = '0;
						next_state = bdcs_pkg::ST_TX;
					end
				end
			endcase
		end
		// System reset returns the control set to defaults but keeps the causes.
		if (sys_rst) begin
			next_control = bdcs_pkg::CONTROL_RESET;
			next_wdg_fired = 1'b0;
		end
	end

	// Registers only; status survives system resets, only power-on reset or a clear command clears it.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= bdcs_pkg::ST_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			byte_idx <= 2'h0;
			reading <= 1'b0;
			command <= 8'h00;
			sda_low <= 1'b0;
			control <= bdcs_pkg::CONTROL_RESET;
			status_first <= bdcs_pkg::STATUS_RESET;
			status_second_sticky <= bdcs_pkg::STATUS_RESET;
			wdg_fired <= 1'b0;
			full_reset_o <= 1'b0;
		end else begin
			state <= next_state;
			shift <= next_shift;
			bit_cnt <= next_bit_cnt;
			byte_idx <= next_byte_idx;
			reading <= next_reading;
			command <= next_command;
			sda_low <= next_sda_low;
			control <= next_control;
			status_first <= next_status_first;
			status_second_sticky <= next_status_second_sticky;
			wdg_fired <= next_wdg_fired;
			full_reset_o <= next_control[bdcs_pkg::CTRL_FULL_RESET_BIT] | next_wdg_fired;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_low;
	assign gp_led_o = control[bdcs_pkg::CTRL_GP_LED_BIT];
	assign pg_led_blink_o = control[bdcs_pkg::CTRL_PG_LED_BIT];
	assign handle_disable_o = control[bdcs_pkg::CTRL_HANDLE_DISABLE_BIT];
	assign handle_reset_mode_o = control[bdcs_pkg::CTRL_HANDLE_MODE_BIT];

endmodule

`default_nettype wire

/* dv/bdcs_host_model.sv */
// Host SMBus controller model that issues byte-data write and read cycles.
// Assumes the testbench builds the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module bdcs_host_model (
	// Clock for bit timing.
	input wire logic ref_clk_i,
	// Wire level of SDA.
	input wire logic sda_i,
	// Bus drive.
	output logic scl_o,
	output logic sda_low_o
);
	// ----------------------------------------------------------------
	// Bit timing
	// ----------------------------------------------------------------
	// SCL idles high between frames and stands still there.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// Waits whole clocks, then steps just past the edge.
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Twelve clocks a phase keeps well clear of the pin filter and its latency.
	task automatic bit_io(input logic b, output logic r);
		wait_n(6);
		sda_low_o = !b;
		wait_n(6);
		scl_o = 1'b1;
		wait_n(6);
		r = sda_i;
		wait_n(6);
		scl_o = 1'b0;
	endtask
	// Start and repeated start share one shape.
	task automatic start();
		wait_n(6);
		sda_low_o = 1'b0;
		wait_n(6);
		scl_o = 1'b1;
		wait_n(6);
		sda_low_o = 1'b1;
		wait_n(6);
		scl_o = 1'b0;
	endtask
	// Stop leaves both lines released.
	task automatic stop();
		wait_n(6);
		sda_low_o = 1'b1;
		wait_n(6);
		scl_o = 1'b1;
		wait_n(6);
		sda_low_o = 1'b0;
		wait_n(6);
	endtask
	// Eight bits MSB first, then the slave's acknowledge is sampled.
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// ----------------------------------------------------------------
	// Byte-data cycles
	// ----------------------------------------------------------------
	// Only the byte-data write format is ever sent.
	task automatic write_cycle(input logic [7:0] addr, input logic [7:0] cmd,
			input logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte(addr, a0);
		send_byte(cmd, a1);
		send_byte(data, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask
	// Byte-data read with repeated start; the master NACKs its one byte.
	task automatic read_cycle(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
		logic a0, a1, a2, r;
		start();
		send_byte(bdcs_pkg::DEV_ADDR, a0);
		send_byte(cmd, a1);
		start();
		send_byte(bdcs_pkg::DEV_ADDR | 8'h01, a2);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(1'b1, r);
		stop();
		ok = a0 && a1 && a2;
	endtask
endmodule
`default_nettype wire

/* dv/bdcs_regs_properties.sv */
// Concurrent checks on the pins of the register set.
// Assumes SCL phases of at least ten clocks, as the host model keeps.
`timescale 1ns/1ps
`default_nettype none

module bdcs_regs_checker (
	// Clock and resets.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sys_rst_n_i,
	// SMBus pins.
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Supply monitors and board controls.
	input wire logic [7:0] power_fail_first_i,
	input wire logic [4:0] power_fail_second_i,
	input wire logic full_reset_o,
	input wire logic gp_led_o,
	input wire logic pg_led_blink_o,
	input wire logic handle_disable_o,
	input wire logic handle_reset_mode_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Open drain: the data level is never driven high.
	property p_sda_const;
		sda_o == 1'b0;
	endproperty
	a_sda_const: assert property (p_sda_const)
		else $error("sda_o driven high");
	// The slave moves SDA only in the low phase just after an SCL fall.
	property p_oe_window;
		$changed(sda_oe_o) |-> !scl_i && $past(scl_i, 8);
	endproperty
	a_oe_window: assert property (p_oe_window)
		else $error("sda_oe_o changed outside the low phase after SCL fell");
	// A driven ack or data bit stands through the SCL high phase.
	property p_oe_hold;
		sda_oe_o && scl_i |=> sda_oe_o;
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("sda_oe_o released while SCL high");
	// Bus drive, reset request and both LEDs are quiet at the first edge after power-on reset.
	property p_rst_quiet;
		$fell(rst_i) |-> !sda_oe_o && !full_reset_o && !gp_led_o && !pg_led_blink_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active right after reset");
	// A held system reset clears control outputs and the fired watchdog.
	property p_sysrst;
		!sys_rst_n_i [*8] |-> ##2 !full_reset_o && !gp_led_o && !pg_led_blink_o
			&& !handle_disable_o && !handle_reset_mode_o;
	endproperty
	a_sysrst: assert property (p_sysrst)
		else $error("control outputs survive system reset");
	// Control outputs change only at a write (SCL low) or a system reset.
	property p_ctrl_window;
		$changed({gp_led_o, pg_led_blink_o, handle_disable_o, handle_reset_mode_o})
			|-> !scl_i || !sys_rst_n_i;
	endproperty
	a_ctrl_window: assert property (p_ctrl_window)
		else $error("control output changed outside a write");
	// The reset request drops only through a write or a system reset.
	property p_fr_drop;
		$fell(full_reset_o) |-> !scl_i || !sys_rst_n_i;
	endproperty
	a_fr_drop: assert property (p_fr_drop)
		else $error("full_reset_o dropped on its own");
	// On an idle bus the reset request holds.
	property p_fr_hold;
		full_reset_o && scl_i && sys_rst_n_i |=> full_reset_o;
	endproperty
	a_fr_hold: assert property (p_fr_hold)
		else $error("full_reset_o not held");
endmodule

bind bdcs_regs bdcs_regs_checker u_bdcs_regs_checker (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sys_rst_n_i(sys_rst_n_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.power_fail_first_i(power_fail_first_i), .power_fail_second_i(power_fail_second_i),
	.full_reset_o(full_reset_o), .gp_led_o(gp_led_o), .pg_led_blink_o(pg_led_blink_o),
	.handle_disable_o(handle_disable_o), .handle_reset_mode_o(handle_reset_mode_o)
);
`default_nettype wire

/* dv/test_board_control_status_regs.sv */
// Self-checking testbench of the register set driven by the host model.
// Assumes a 1 ms tick shortened to 20 clocks, so the 2 s timeout is 40000 clocks.
`timescale 1ns/1ps
`default_nettype none

module test_board_control_status_regs;
	// Clock, resets, pins and counters.
	logic ref_clk_i, rst_i, sys_rst_n_i, scl, sda, host_low, sda_o, sda_oe_o;
	logic [7:0] pf_first;
	logic [4:0] pf_second;
	logic full_reset_o, gp_led_o, pg_led_blink_o, handle_disable_o, handle_reset_mode_o;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	// Pull-up: the wire is high unless a party pulls it low.
	assign sda = !(sda_oe_o || host_low);

	bdcs_regs #(.TICK_CYCLES(20), .REVISION(8'h3C)) u_bdcs_regs (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sys_rst_n_i(sys_rst_n_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.power_fail_first_i(pf_first), .power_fail_second_i(pf_second),
		.full_reset_o(full_reset_o), .gp_led_o(gp_led_o), .pg_led_blink_o(pg_led_blink_o),
		.handle_disable_o(handle_disable_o), .handle_reset_mode_o(handle_reset_mode_o));
	bdcs_host_model u_bdcs_host_model (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
		.sda_low_o(host_low));

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = !ref_clk_i;
	end
	always @(posedge ref_clk_i) cyc <= cyc + 1;
	// Counts every compare and reports a mismatch at once.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		logic ok;
		u_bdcs_host_model.write_cycle(bdcs_pkg::DEV_ADDR, cmd, data, ok);
		check("write_ack", {7'h00, ok}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_bdcs_host_model.read_cycle(cmd, d, ok);
		check("read_ack", {7'h00, ok}, 8'h01);
		check("read_data", d, exp);
	endtask
	// Packs the board controls as full, gp, pg, handle disable, handle mode.
	function automatic logic [7:0] outs();
		return {3'h0, full_reset_o, gp_led_o, pg_led_blink_o, handle_disable_o,
			handle_reset_mode_o};
	endfunction
	task automatic sys_pulse();
		sys_rst_n_i = 1'b0;
		idle(12);
		sys_rst_n_i = 1'b1;
		idle(10);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_control();
		wr(8'hA0, 8'hE2);
		check("ctrl_outs", outs(), 8'h0F);
		rd(8'hA1, 8'hE2);
		// Mapped codes are only used in their own direction; unmapped ones are acknowledged, change nothing and read FF.
		wr(8'hA2, 8'h00);
		rd(8'hA1, 8'hE2);
		rd(8'hA2, 8'hFF);
		wr(8'hA0, 8'hE3);
		check("full_reset", outs(), 8'h1F);
		wr(8'hA0, 8'hE2);
		check("full_reset", outs(), 8'h0F);
	endtask
	// Causes are pulsed, so only sticky storage can report them later.
	task automatic t_status();
		pf_first = 8'h81;
		pf_second = 5'h15;
		idle(10);
		pf_first = 8'h00;
		pf_second = 5'h00;
		idle(10);
		rd(8'hB1, 8'h81);
		rd(8'hB3, 8'h15);
		sys_pulse();
		check("sys_outs", outs(), 8'h00);
		rd(8'hA1, 8'h00);
		rd(8'hB1, 8'h81);
		wr(8'hB0, 8'h5A);
		rd(8'hB1, 8'h00);
		rd(8'hB3, 8'h15);
		wr(8'hB2, 8'hA5);
		rd(8'hB3, 8'h00);
	endtask
	task automatic t_misc();
		logic ok;
		rd(8'hC1, 8'h3C);
		wr(8'hC0, 8'h00);
		rd(8'hC1, 8'h3C);
		rd(8'h77, 8'hFF);
		wr(8'hA0, 8'h12);
		wr(8'h77, 8'hFF);
		rd(8'hA1, 8'h12);
		u_bdcs_host_model.write_cycle(8'h5E, 8'hA0, 8'hFF, ok);
		check("addr_ack", {7'h00, ok}, 8'h00);
		rd(8'hA1, 8'h12);
	endtask
	// Timeout select 00 is 2000 ticks of 20 clocks after the first edge of bit 2.
	task automatic t_watchdog();
		int t0;
		wr(8'hA0, 8'h04);
		t0 = cyc;
		rd(8'hB3, 8'h80);
		idle(22000 - (cyc - t0));
		rd(8'hB3, 8'hA0);
		// Longer selections push the half mark past the elapsed count; bit 2 stays 1.
		wr(8'hA0, 8'h14);
		rd(8'hB3, 8'h80);
		wr(8'hA0, 8'h0C);
		rd(8'hB3, 8'h80);
		wr(8'hA0, 8'h1C);
		rd(8'hB3, 8'h80);
		wr(8'hA0, 8'h04);
		rd(8'hB3, 8'hA0);
		while (!full_reset_o && cyc - t0 < 45000) idle(1);
		check("wdg_time", {7'h00, (cyc - t0 > 39800) && (cyc - t0 < 40100)}, 8'h01);
		rd(8'hB3, 8'h40);
		sys_pulse();
		check("wdg_clear", outs(), 8'h00);
		rd(8'hB3, 8'h40);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// The run needs about 64000 clocks; a hang is cut off well beyond that.
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		err_count++;
		print_verdict();
	end
	initial begin
		rst_i = 1'b1;
		sys_rst_n_i = 1'b1;
		pf_first = 8'h00;
		pf_second = 5'h00;
		repeat (4) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		idle(1);
		check("reset_outs", outs(), 8'h00);
		idle(4);
		t_control();
		t_status();
		t_misc();
		t_watchdog();
		print_verdict();
	end
endmodule
`default_nettype wire
